// >>> inc/rtcc_if.sv
`default_nettype none
interface rtcc_if;
  logic        sel_status;
  logic        sel_preset;
  logic        rd;
  logic        wr;
  logic [1:0]  be;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        ack;
  logic        stall;
  logic        internal_bus_grant;
  logic        irq_req;
  logic        irq_done;

  modport dev  (input  sel_status, sel_preset, rd, wr, be, wdata, irq_done,
                output rdata, ack, stall, internal_bus_grant, irq_req);
  modport host (output sel_status, sel_preset, rd, wr, be, wdata, irq_done,
                input  rdata, ack, stall, internal_bus_grant, irq_req);
endinterface : rtcc_if
`default_nettype wire

// >>> inc/rtcc_pkg.sv
`default_nettype none
package rtcc_pkg;
  localparam int unsigned CLK_HZ      = 125_000_000;
  localparam int unsigned OSC_HZ      = 20_000_000;
  // 125 MHz does not divide into 20 MHz; the oscillator tick is rounded down
  localparam int unsigned OSC_DIV_CYC = CLK_HZ / OSC_HZ;
  localparam int unsigned DEC_MOD     = 10;
  localparam int unsigned DIV_STAGES  = 4;
  localparam int unsigned DATA_W      = 16;

  // decade counter codes that mark time pulses and the 1 MHz wrap
  localparam logic [3:0] DEC_TP0  = 4'h0;
  localparam logic [3:0] DEC_TP1  = 4'h2;
  localparam logic [3:0] DEC_TS2  = 4'h3;
  localparam logic [3:0] DEC_LAST = 4'h9;

  // status register field positions
  localparam int unsigned B_EN      = 0;
  localparam int unsigned B_RATE_LO = 1;
  localparam int unsigned B_RATE_HI = 3;
  localparam int unsigned B_MIRQ    = 6;
  localparam int unsigned B_MFLAG   = 7;
  localparam int unsigned B_MODE_LO = 8;
  localparam int unsigned B_MODE_HI = 9;
  localparam int unsigned B_MST2    = 10;
  localparam int unsigned B_MCNT    = 11;
  localparam int unsigned B_MST1    = 12;
  localparam int unsigned B_T1EN    = 13;
  localparam int unsigned B_T1IRQ   = 14;
  localparam int unsigned B_T1FLAG  = 15;

  localparam logic [15:0] STAT_RST     = 16'h0000;
  localparam logic [15:0] STAT_STORE_M = 16'hE3CF;
  localparam logic [15:0] PRESET_RST   = 16'h0000;

  typedef enum logic [1:0] {
    RTCC_MODE_SINGLE = 2'b00,
    RTCC_MODE_REPEAT = 2'b01,
    RTCC_MODE_EVENT  = 2'b10,
    RTCC_MODE_ZERO   = 2'b11
  } rtcc_mode_t;

  typedef enum logic [2:0] {
    RTCC_RATE_NONE  = 3'b000,
    RTCC_RATE_1M    = 3'b001,
    RTCC_RATE_100K  = 3'b010,
    RTCC_RATE_10K   = 3'b011,
    RTCC_RATE_1K    = 3'b100,
    RTCC_RATE_100   = 3'b101,
    RTCC_RATE_TRIG  = 3'b110,
    RTCC_RATE_MAINS = 3'b111
  } rtcc_rate_t;

  typedef enum logic [0:0] {
    RTCC_H_IDLE = 1'b0,
    RTCC_H_WAIT = 1'b1
  } rtcc_hstate_t;
endpackage : rtcc_pkg
`default_nettype wire

// >>> rtl/rtcc_device.sv
`default_nettype none
// Function
// - status byte/word access; bits 12:10,5:4 read zero
// - preset buffer loads bus data or counter
// - preset write loads counter while disabled
// - software writes preset before status
// - counter readable only via capture in modes 2/3
// - 20 MHz halved, decade counter, five time states
// - msb makes state 4 null; pulses gate lsb
// - status select plus write loads, plus read returns
// - host preset writes only in time state two
// - select sets stall; sync at pulse zero clears
// - enabled 1 MHz through four decade stages
// - bits 3:1 select count source
// - maintenance bit 12 acts as trigger one
// - maintenance bit 11 injects one chain pulse
// - mains edge capture, count input, cleared pulse zero
// - trigger one synchronised to 1 MHz feeds mux
// - trigger one sets flag 15, maybe interrupt
// - software clears flag 15; readable anytime
// - overflow in modes 0/1 or capture sets flag 7, interrupt if bit 6
// - simultaneous events give one interrupt
// - bits 9:8 select mode behaviour
// - enable set by trigger, cleared single overflow
// - bit 13 lets trigger one enable counting
module rtcc_device
  import rtcc_pkg::*;
#(
  parameter int unsigned OSC_DIV = OSC_DIV_CYC
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_b_i,
  rtcc_if.dev       bus,
  input  wire logic trig1_i,
  input  wire logic trig2_i,
  input  wire logic mains_edge_input_i,
  output logic      overflow_reload_pulse_o
);
  localparam logic [3:0] OSC_LAST = 4'(OSC_DIV - 1);

  logic [3:0]  osc_r,  osc_nxt;
  logic        half_r, half_nxt;
  logic [3:0]  dec_r,  dec_nxt;
  logic [2:0]  meta_r, sync_r, prev_r;
  logic [3:0]  div_r [DIV_STAGES];
  logic [3:0]  div_nxt [DIV_STAGES];
  logic [15:0] stat_r, stat_nxt;
  logic [15:0] buf_r,  buf_nxt;
  logic [15:0] cnt_r,  cnt_nxt;
  logic        st1p_r, st1p_nxt, st2p_r, st2p_nxt;
  logic        ckbf_r, ckbf_nxt, lcap_r, lcap_nxt, cin_r, cin_nxt;
  logic        ovld_r, ovld_nxt, stall_r, stall_nxt, sync_ff_r, sync_nxt;
  logic        done_r, done_nxt, ack_r, ack_nxt, grant_r, grant_nxt;
  logic        irq_r,  irq_nxt, ovo_r;
  logic [15:0] rdata_r, rdata_nxt;
  logic        osc_tick, ten_tick, one_mhz, tp0, tp1, ts2;
  logic        sw, pw, m10, m11, m12, st1, cap, reload, line_pulse, cnt_pulse;
  logic [DIV_STAGES:0] rate;
  logic [15:0] wmerge, pmerge;
  rtcc_mode_t  mode;

  assign bus.rdata              = rdata_r;
  assign bus.ack                = ack_r;
  assign bus.stall              = stall_r;
  assign bus.internal_bus_grant = grant_r;
  assign bus.irq_req            = irq_r;
  assign overflow_reload_pulse_o = ovo_r;

  // timing generator
  always_comb begin
    osc_tick = (osc_r == OSC_LAST);
    osc_nxt  = osc_tick ? 4'h0 : osc_r + 4'h1;
    half_nxt = half_r ^ osc_tick;
    ten_tick = osc_tick & half_r;
    dec_nxt  = dec_r;
    if (ten_tick) begin
      dec_nxt = (dec_r == DEC_LAST) ? 4'h0 : dec_r + 4'h1;
    end
    // pulses fire on entry to odd codes; msb high blocks state 4
    tp0     = ten_tick & (dec_r == DEC_TP0) & ~dec_r[3];
    tp1     = ten_tick & (dec_r == DEC_TP1) & ~dec_r[3];
    ts2     = ten_tick & (dec_r == DEC_TS2);
    one_mhz = ten_tick & (dec_r == DEC_LAST);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      osc_r  <= 4'h0;
      half_r <= 1'b0;
      dec_r  <= 4'h0;
      meta_r <= 3'b000;
      sync_r <= 3'b000;
      prev_r <= 3'b000;
    end else begin
      osc_r  <= osc_nxt;
      half_r <= half_nxt;
      dec_r  <= dec_nxt;
      meta_r <= {mains_edge_input_i, trig2_i, trig1_i};
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // main datapath
  always_comb begin
    mode   = rtcc_mode_t'(stat_r[B_MODE_HI:B_MODE_LO]);
    sw     = bus.sel_status & bus.wr & ~ack_r;
    wmerge = stat_r;
    if (bus.be[0]) wmerge[7:0] = bus.wdata[7:0];
    if (bus.be[1]) wmerge[15:8] = bus.wdata[15:8];
    m10 = sw & bus.be[1] & bus.wdata[B_MST2];
    m11 = sw & bus.be[1] & bus.wdata[B_MCNT];
    m12 = sw & bus.be[1] & bus.wdata[B_MST1];

    // trigger one waits for the next 1 MHz tick
    st1p_nxt = (sync_r[0] & ~prev_r[0]) | (st1p_r & ~one_mhz);
    st1      = (st1p_r & one_mhz) | m12;

    st2p_nxt = (sync_r[1] & ~prev_r[1]) | m10 | (st2p_r & ~tp1);
    ckbf_nxt = (st2p_r & tp1) | (ckbf_r & ~ts2);
    cap      = ckbf_r & ts2 & mode[1];

    lcap_nxt = (sync_r[2] & ~prev_r[2]) | (lcap_r & ~cin_r);
    // a capture landing on pulse zero must still arm, or it counts twice
    cin_nxt  = (cin_r & ~tp0) | lcap_r;
    line_pulse = lcap_r & ~cin_r;

    rate[0] = (one_mhz & stat_r[B_EN]) | m11;
    for (int i = 0; i < DIV_STAGES; i++) begin
      div_nxt[i] = div_r[i];
      if (rate[i]) begin
        div_nxt[i] = (div_r[i] == DEC_LAST) ? 4'h0 : div_r[i] + 4'h1;
      end
      rate[i+1] = rate[i] & (div_r[i] == DEC_LAST);
    end

    unique case (rtcc_rate_t'(stat_r[B_RATE_HI:B_RATE_LO]))
      RTCC_RATE_NONE:  cnt_pulse = 1'b0;
      RTCC_RATE_1M:    cnt_pulse = rate[0];
      RTCC_RATE_100K:  cnt_pulse = rate[1];
      RTCC_RATE_10K:   cnt_pulse = rate[2];
      RTCC_RATE_1K:    cnt_pulse = rate[3];
      RTCC_RATE_100:   cnt_pulse = rate[4];
      // the external trigger still counts while disabled
      RTCC_RATE_TRIG:  cnt_pulse = st1;
      RTCC_RATE_MAINS: cnt_pulse = line_pulse & stat_r[B_EN];
    endcase

    reload   = ovld_r & tp0 & ~mode[1];
    // held until the reload pulse, so an overflow between pulses is kept
    ovld_nxt = (cnt_pulse & (&cnt_r) & ~mode[1]) | (ovld_r & ~tp0);

    // preset bus transfers
    stall_nxt = (bus.sel_preset & ~stall_r & ~sync_ff_r & ~done_r)
              | (stall_r & ~sync_ff_r);
    sync_nxt  = bus.sel_preset & (sync_ff_r | (stall_r & tp0));
    pw        = sync_ff_r & bus.wr & ts2 & ~done_r;
    pmerge    = buf_r;
    if (bus.be[0]) pmerge[7:0] = bus.wdata[7:0];
    if (bus.be[1]) pmerge[15:8] = bus.wdata[15:8];

    buf_nxt = buf_r;
    if (cap) buf_nxt = cnt_r;
    else if (pw) buf_nxt = pmerge;

    cnt_nxt = cnt_r;
    if (pw & ~stat_r[B_EN]) cnt_nxt = pmerge;
    else if (cap & (mode == RTCC_MODE_ZERO)) cnt_nxt = 16'h0000;
    else if (reload) cnt_nxt = buf_r;
    else if (cnt_pulse) cnt_nxt = cnt_r + 16'h0001;

    // status: hardware events are applied after the write so sets win
    stat_nxt = sw ? (wmerge & STAT_STORE_M) : stat_r;
    if (st1) stat_nxt[B_T1FLAG] = 1'b1;
    if (st1 & stat_r[B_T1EN]) stat_nxt[B_EN] = 1'b1;
    if (reload | cap) stat_nxt[B_MFLAG] = 1'b1;
    if (reload & (mode == RTCC_MODE_SINGLE)) stat_nxt[B_EN] = 1'b0;

    // one flip-flop merges both sources into a single request
    irq_nxt = (st1 & stat_r[B_T1IRQ]) | ((reload | cap) & stat_r[B_MIRQ])
            | (irq_r & ~bus.irq_done);

    done_nxt  = bus.sel_preset & (done_r | (sync_ff_r & (bus.rd | pw)));
    ack_nxt   = (bus.sel_status & ~ack_r)
              | (sync_ff_r & ~done_r & (bus.rd | pw));
    grant_nxt = bus.sel_status | bus.sel_preset;
    rdata_nxt = 16'h0000;
    // read data only in the acknowledge cycle, zero while select lingers
    if (bus.sel_status & bus.rd & ~ack_r) begin
      rdata_nxt = stat_r & STAT_STORE_M;
    end else if (sync_ff_r & ~done_r & bus.rd) begin
      rdata_nxt = buf_r;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < DIV_STAGES; i++) div_r[i] <= 4'h0;
      stat_r  <= STAT_RST;
      buf_r   <= PRESET_RST;
      cnt_r   <= PRESET_RST;
      st1p_r  <= 1'b0;
      st2p_r  <= 1'b0;
      ckbf_r  <= 1'b0;
      lcap_r  <= 1'b0;
      cin_r   <= 1'b0;
      ovld_r  <= 1'b0;
      stall_r <= 1'b0;
      sync_ff_r <= 1'b0;
      done_r  <= 1'b0;
      ack_r   <= 1'b0;
      grant_r <= 1'b0;
      irq_r   <= 1'b0;
      ovo_r   <= 1'b0;
      rdata_r <= 16'h0000;
    end else begin
      for (int i = 0; i < DIV_STAGES; i++) div_r[i] <= div_nxt[i];
      stat_r  <= stat_nxt;
      buf_r   <= buf_nxt;
      cnt_r   <= cnt_nxt;
      st1p_r  <= st1p_nxt;
      st2p_r  <= st2p_nxt;
      ckbf_r  <= ckbf_nxt;
      lcap_r  <= lcap_nxt;
      cin_r   <= cin_nxt;
      ovld_r  <= ovld_nxt;
      stall_r <= stall_nxt;
      sync_ff_r <= sync_nxt;
      done_r  <= done_nxt;
      ack_r   <= ack_nxt;
      grant_r <= grant_nxt;
      irq_r   <= irq_nxt;
      ovo_r   <= reload;
      rdata_r <= rdata_nxt;
    end
  end
endmodule : rtcc_device
`default_nettype wire

// >>> rtl/rtcc_host.sv
`default_nettype none
module rtcc_host
  import rtcc_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  rtcc_if.host             bus,
  input  wire logic        cmd_valid_i,
  input  wire logic        cmd_preset_i,
  input  wire logic        cmd_write_i,
  input  wire logic [1:0]  cmd_be_i,
  input  wire logic [15:0] cmd_wdata_i,
  input  wire logic        irq_ack_i,
  output logic             cmd_ready_o,
  output logic             rsp_valid_o,
  output logic [15:0]      rsp_rdata_o,
  output logic             irq_o
);
  rtcc_hstate_t st_r, st_nxt;
  logic        sel_s_r, sel_s_nxt, sel_p_r, sel_p_nxt;
  logic        rd_r, rd_nxt, wr_r, wr_nxt, done_r, done_nxt;
  logic [1:0]  be_r, be_nxt;
  logic [15:0] wd_r, wd_nxt, rsp_r, rsp_nxt;
  logic        rv_r, rv_nxt, irq_r, rdy_r;

  assign bus.sel_status = sel_s_r;
  assign bus.sel_preset = sel_p_r;
  assign bus.rd         = rd_r;
  assign bus.wr         = wr_r;
  assign bus.be         = be_r;
  assign bus.wdata      = wd_r;
  assign bus.irq_done   = done_r;
  assign cmd_ready_o    = rdy_r;
  assign rsp_valid_o    = rv_r;
  assign rsp_rdata_o    = rsp_r;
  assign irq_o          = irq_r;

  always_comb begin
    st_nxt    = st_r;
    sel_s_nxt = sel_s_r;
    sel_p_nxt = sel_p_r;
    rd_nxt    = rd_r;
    wr_nxt    = wr_r;
    be_nxt    = be_r;
    wd_nxt    = wd_r;
    rsp_nxt   = rsp_r;
    rv_nxt    = 1'b0;
    // preset/status ordering is left to the user command stream
    unique case (st_r)
      RTCC_H_IDLE: begin
        if (cmd_valid_i) begin
          sel_s_nxt = ~cmd_preset_i;
          sel_p_nxt = cmd_preset_i;
          rd_nxt    = ~cmd_write_i;
          wr_nxt    = cmd_write_i;
          be_nxt    = cmd_be_i;
          wd_nxt    = cmd_wdata_i;
          st_nxt    = RTCC_H_WAIT;
        end
      end
      RTCC_H_WAIT: begin
        // hold the select until the device stops stalling and answers
        if (bus.ack) begin
          sel_s_nxt = 1'b0;
          sel_p_nxt = 1'b0;
          rd_nxt    = 1'b0;
          wr_nxt    = 1'b0;
          rsp_nxt   = bus.rdata;
          rv_nxt    = 1'b1;
          st_nxt    = RTCC_H_IDLE;
        end
      end
    endcase
    done_nxt = irq_ack_i & bus.irq_req & ~done_r;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      st_r    <= RTCC_H_IDLE;
      sel_s_r <= 1'b0;
      sel_p_r <= 1'b0;
      rd_r    <= 1'b0;
      wr_r    <= 1'b0;
      be_r    <= 2'b00;
      wd_r    <= 16'h0000;
      rsp_r   <= 16'h0000;
      rv_r    <= 1'b0;
      done_r  <= 1'b0;
      irq_r   <= 1'b0;
      rdy_r   <= 1'b1;
    end else begin
      st_r    <= st_nxt;
      sel_s_r <= sel_s_nxt;
      sel_p_r <= sel_p_nxt;
      rd_r    <= rd_nxt;
      wr_r    <= wr_nxt;
      be_r    <= be_nxt;
      wd_r    <= wd_nxt;
      rsp_r   <= rsp_nxt;
      rv_r    <= rv_nxt;
      done_r  <= done_nxt;
      irq_r   <= bus.irq_req;
      rdy_r   <= (st_nxt == RTCC_H_IDLE);
    end
  end
endmodule : rtcc_host
`default_nettype wire

// >>> sim/lab_realtime_clock_counter_tb.sv
`default_nettype none
module lab_realtime_clock_counter_tb
  import rtcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_i;
  logic        rst_b_i;
  logic        cmd_valid;
  logic        cmd_preset;
  logic        cmd_write;
  logic [1:0]  cmd_be;
  logic [15:0] cmd_wdata;
  logic        irq_ack;
  logic [2:0]  pins;
  logic        cmd_ready;
  logic        rsp_valid;
  logic [15:0] rsp_rdata;
  logic        irq;
  logic        ovf;
  int          bad_count;
  int          compares;
  rtcc_if u_bus ();
  // fast oscillator divide: 1 MHz tick every 40 clocks
  rtcc_device #(.OSC_DIV(2)) i_rtcc_device (.clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i), .bus(u_bus.dev), .trig1_i(pins[0]),
    .trig2_i(pins[1]), .mains_edge_input_i(pins[2]),
    .overflow_reload_pulse_o(ovf));
  rtcc_host i_rtcc_host (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .bus(u_bus.host), .cmd_valid_i(cmd_valid), .cmd_preset_i(cmd_preset),
    .cmd_write_i(cmd_write), .cmd_be_i(cmd_be), .cmd_wdata_i(cmd_wdata),
    .irq_ack_i(irq_ack), .cmd_ready_o(cmd_ready), .rsp_valid_o(rsp_valid),
    .rsp_rdata_o(rsp_rdata), .irq_o(irq));
  rtcc_properties i_rtcc_properties (.clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i), .sel_status(u_bus.sel_status),
    .sel_preset(u_bus.sel_preset), .rd(u_bus.rd), .ack(u_bus.ack),
    .stall(u_bus.stall), .internal_bus_grant(u_bus.internal_bus_grant),
    .irq_req(u_bus.irq_req), .irq_done(u_bus.irq_done),
    .rdata(u_bus.rdata));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out;
    $display("counts: %0d compares, %0d bad", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  // k 0 waits on overflow, 1 on irq; lvl is the level waited for
  task automatic wait_for(input int k, input logic lvl);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (((k == 0) ? ovf : irq) !== lvl && n < 400);
    check({15'h0000, n < 400}, 16'h0001);
    if (n >= 400) close_out();
  endtask : wait_for
  task automatic irq_clear;
    irq_ack <= 1'b1;
    wait_for(1, 1'b0);
    irq_ack <= 1'b0;
  endtask : irq_clear
  task automatic xact(input logic p, input logic w, input logic [1:0] be,
                      input logic [15:0] d, output logic [15:0] q);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (cmd_ready !== 1'b1 && n < 400);
    cmd_valid  <= 1'b1;
    cmd_preset <= p;
    cmd_write  <= w;
    cmd_be     <= be;
    cmd_wdata  <= d;
    @(posedge clk_sys_i);
    cmd_valid <= 1'b0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (rsp_valid !== 1'b1 && n < 800);
    q = rsp_rdata;
    if (n >= 800) begin
      check(16'h0000, 16'h0001);
      close_out();
    end
  endtask : xact
  task automatic wr(input logic p, input logic [1:0] be, input logic [15:0] d);
    logic [15:0] q;
    xact(p, 1'b1, be, d, q);
  endtask : wr
  task automatic expect_reg(input logic p, input logic [15:0] e);
    logic [15:0] q;
    xact(p, 1'b0, 2'b11, 16'h0000, q);
    check(q, e);
  endtask : expect_reg
  task automatic pulse(input int k);
    pins <= 3'h1 << k;
    repeat (8) @(posedge clk_sys_i);
    pins <= 3'h0;
  endtask : pulse
  task automatic t_status;
    expect_reg(1'b0, STAT_RST);
    expect_reg(1'b1, PRESET_RST);
    wr(1'b0, 2'b01, 16'h00FE);
    expect_reg(1'b0, 16'h00CE);
    wr(1'b0, 2'b10, 16'h63FF);
    expect_reg(1'b0, 16'h63CE);
    wr(1'b0, 2'b11, 16'h1000);
    repeat (100) @(posedge clk_sys_i);
    // bits 13 and 14 were still set, so the trigger enables and interrupts
    expect_reg(1'b0, 16'h8001);
    wait_for(1, 1'b1);
    irq_clear();
    wr(1'b0, 2'b11, 16'h0000);
    expect_reg(1'b0, 16'h0000);
    $display("t_status done");
  endtask : t_status
  task automatic t_capture;
    wr(1'b1, 2'b11, 16'h1234);
    wr(1'b0, 2'b11, 16'h0201);
    // enabled now, so this write must leave the counter alone
    wr(1'b1, 2'b11, 16'hABCD);
    expect_reg(1'b1, 16'hABCD);
    pulse(1);
    repeat (120) @(posedge clk_sys_i);
    expect_reg(1'b1, 16'h1234);
    expect_reg(1'b0, 16'h0281);
    $display("t_capture done");
  endtask : t_capture
  task automatic t_counting;
    wr(1'b0, 2'b11, 16'h0000);
    wr(1'b1, 2'b11, 16'hFFFF);
    wr(1'b0, 2'b11, 16'h0043);
    wait_for(0, 1'b1);
    wait_for(1, 1'b1);
    irq_clear();
    expect_reg(1'b0, 16'h00C2);
    wr(1'b0, 2'b11, 16'h010F);
    pulse(2);
    wait_for(0, 1'b1);
    wr(1'b0, 2'b11, 16'h010C);
    pulse(0);
    wait_for(0, 1'b1);
    repeat (60) @(posedge clk_sys_i);
    expect_reg(1'b0, 16'h818C);
    $display("t_counting done");
  endtask : t_counting
  task automatic t_maint;
    wr(1'b1, 2'b11, 16'h5A5A);
    wr(1'b0, 2'b11, 16'h0002);
    // one injected pulse while disabled at the 1 MHz rate
    wr(1'b0, 2'b11, 16'h0802);
    wr(1'b0, 2'b11, 16'h0700);
    repeat (60) @(posedge clk_sys_i);
    expect_reg(1'b1, 16'h5A5B);
    expect_reg(1'b0, 16'h0380);
    wr(1'b0, 2'b11, 16'h0600);
    repeat (60) @(posedge clk_sys_i);
    expect_reg(1'b1, 16'h0000);
    $display("t_maint done");
  endtask : t_maint
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    rst_b_i    = 1'b0;
    cmd_valid  = 1'b0;
    cmd_preset = 1'b0;
    cmd_write  = 1'b0;
    cmd_be     = 2'b00;
    cmd_wdata  = 16'h0000;
    irq_ack    = 1'b0;
    pins       = 3'h0;
    bad_count  = 0;
    compares   = 0;
    repeat (3) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    t_status();
    t_capture();
    t_counting();
    t_maint();
    close_out();
  end
endmodule : lab_realtime_clock_counter_tb
`default_nettype wire

// >>> sim/rtcc_properties.sv
`default_nettype none
module rtcc_properties (
  input wire logic        clk_sys_i,
  input wire logic        rst_b_i,
  input wire logic        sel_status,
  input wire logic        sel_preset,
  input wire logic        rd,
  input wire logic        ack,
  input wire logic        stall,
  input wire logic        internal_bus_grant,
  input wire logic        irq_req,
  input wire logic        irq_done,
  input wire logic [15:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  sequence s_pre_sel;
    $rose(sel_preset);
  endsequence
  // a preset access waits for time pulse zero, and a preset write then also for time state two
  sequence s_pre_ack;
    ##[2:180] ack;
  endsequence
  a_status_ack_next: assert property ($rose(sel_status) |=> ack)
    else $error("status select not answered next cycle");
  a_ack_one_pulse: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_read_zero_bits: assert property (ack && sel_status && rd
    |-> (rdata & 16'h1C30) == 16'h0000)
    else $error("write-only or unused status bits read as one");
  a_idle_rdata_zero: assert property (!ack |-> rdata == 16'h0000)
    else $error("read data driven outside ack");
  a_preset_stall_on: assert property (s_pre_sel |=> stall)
    else $error("preset select did not raise stall");
  a_stall_ends: assert property ($rose(stall) |-> ##[1:90] !stall)
    else $error("stall not released by time pulse zero");
  a_stall_no_ack: assert property (stall |-> !ack)
    else $error("ack while stalled");
  a_preset_answered: assert property (s_pre_sel |-> s_pre_ack)
    else $error("preset access never answered");
  a_grant_on_sel: assert property ((sel_status || sel_preset)
    |=> internal_bus_grant)
    else $error("select without internal bus grant");
  a_irq_held: assert property (irq_req && !irq_done |=> irq_req)
    else $error("interrupt request dropped early");
  a_irq_cleared: assert property (irq_req && irq_done |=> !irq_req)
    else $error("interrupt request not cleared by done");
endmodule : rtcc_properties
`default_nettype wire
